// ===== rtl/dadc_regs.svh
// register offsets, field positions and counts of the dual converter control block
// assumes inclusion by bare name from the package and the design files
`ifndef DADC_REGS_SVH
`define DADC_REGS_SVH

// ------------------------------------------------------------
// apb register map
// ------------------------------------------------------------
`define DADC_OFF_CTRL 12'h000
`define DADC_OFF_CFG 12'h004
`define DADC_OFF_STAT 12'h008
`define DADC_OFF_GAIN 12'h00c
`define DADC_CTRL_SER_OFF 0
`define DADC_CTRL_LSB_FIRST 1
`define DADC_STAT_INCOMPLETE 0
`define DADC_STAT_BUSY 1
`define DADC_STAT_CNT_LSB 8
`define DADC_GAIN_B_LSB 8
`define DADC_CNT_W 8

// ------------------------------------------------------------
// serial frame layout (also used for the cfg read-back)
// ------------------------------------------------------------
`define DADC_FRM_W 16
`define DADC_FRM_LAST 5'h0f
`define DADC_FRM_GAIN_A_LSB 0
`define DADC_FRM_GAIN_B_LSB 5
`define DADC_FRM_OUTPUT_FORMAT_SELECT 10
`define DADC_FRM_MODE 11
`define DADC_FRM_SINGLE_BUS_SELECT 12
`define DADC_GAIN_W 5

// ------------------------------------------------------------
// converter data path
// ------------------------------------------------------------
`define DADC_WORD_W 10
`define DADC_STAGES 5
`define DADC_STAGE_BITS 2
`define DADC_PIPE_DEPTH 4
`define DADC_CHANS 2

`endif

// ===== rtl/dadc_pkg.sv
// types shared by the dual converter control block
// assumes the register header is on the include path
`include "dadc_regs.svh"

package dadc_pkg;

  typedef enum logic [1:0] {
    DADC_SER_IDLE = 2'b00,
    DADC_SER_SHIFT = 2'b01,
    DADC_SER_WAIT = 2'b10,
    DADC_SER_DONE = 2'b11
  } dadc_ser_state_t;

  typedef struct packed {
    logic [`DADC_GAIN_W-1:0] gain_a;
    logic [`DADC_GAIN_W-1:0] gain_b;
    logic output_format_select;
    logic mode;
    logic single_bus_select;
  } dadc_cfg_t;

  typedef struct packed {
    logic sclk_q;
    logic sclk_p;
    logic cs_act_q;
    logic sdi_q;
    dadc_ser_state_t ser_state;
    logic [4:0] bit_cnt;
    logic [`DADC_FRM_W-1:0] shift;
    dadc_cfg_t cfg;
    logic ctrl_ser_off;
    logic ctrl_lsb_first;
    logic stat_incomplete;
    logic [`DADC_CNT_W-1:0] commit_cnt;
    logic pend;
    logic arm;
    logic [`DADC_GAIN_W-1:0] stage_a;
    logic [`DADC_GAIN_W-1:0] stage_b;
    logic [`DADC_GAIN_W-1:0] app_a;
    logic [`DADC_GAIN_W-1:0] app_b;
    logic ph;
    logic hold;
    logic [`DADC_WORD_W-1:0] bus_a;
    logic [`DADC_WORD_W-1:0] bus_b;
    logic [`DADC_WORD_W-1:0] held_b;
    logic out_clk;
    logic bus_is_b;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
  } dadc_state_t;

  typedef struct packed {
    logic [`DADC_PIPE_DEPTH-1:0][`DADC_WORD_W-1:0] dly;
  } dadc_pipe_state_t;

endpackage : dadc_pkg

// ===== rtl/dadc_pipe.sv
// stage alignment and combination of one converter channel
// assumes i_raw carries the five 2-bit stage codes, stage 0 in the top bits
`include "dadc_regs.svh"

module dadc_pipe (
  input wire logic i_clk,
  input wire logic i_rstn,
  input wire logic i_sample,
  input wire logic [`DADC_WORD_W-1:0] i_raw,
  output logic [`DADC_WORD_W-1:0] o_word
);

  dadc_pkg::dadc_pipe_state_t st_r;
  dadc_pkg::dadc_pipe_state_t st_nxt;
  logic [`DADC_WORD_W-1:0] acc;
  logic [`DADC_WORD_W-1:0] src;
  logic [`DADC_STAGE_BITS-1:0] code;

  // ------------------------------------------------------------
  // stage k resolves k sample periods late: delay it by depth-k
  // ------------------------------------------------------------
  always_comb
  begin
    st_nxt = st_r;
    acc = '0;
    src = '0;
    code = '0;
    if (i_sample)
    begin
      st_nxt.dly[0] = i_raw;
      for (int j = 1; j < `DADC_PIPE_DEPTH; j++)
      begin
        st_nxt.dly[j] = st_r.dly[j-1];
      end
    end
    for (int k = 0; k < `DADC_STAGES - 1; k++)
    begin
      src = st_r.dly[`DADC_STAGES-2-k];
      code = src[`DADC_WORD_W-1-`DADC_STAGE_BITS*k -: `DADC_STAGE_BITS];
      acc = acc + (`DADC_WORD_W'(code) << (`DADC_STAGE_BITS * (`DADC_STAGES - 1 - k))); // RULE15
    end
    // last stage resolves in the current period: taken straight from the input
    code = i_raw[`DADC_STAGE_BITS-1:0];
    acc = acc + `DADC_WORD_W'(code); // RULE15
    o_word = acc;
  end

  always_ff @(posedge i_clk or negedge i_rstn)
  begin
    if (!i_rstn)
      st_r <= '0;
    else
      st_r <= st_nxt;
  end

endmodule : dadc_pipe

// ===== rtl/dadc_ctrl.sv
// dual converter digital control: serial configuration write, gain resync,
// output timing options, output format and apb register access
// assumes all pins synchronous to i_clk; i_cnv_clk_en marks each input clock edge
`include "dadc_regs.svh"

// Behaviour
// (RULE1) mode0 dual bus: 80 MHz in, 40 out
// (RULE2) mode1 dual bus: 40 MHz in, 40 out
// (RULE3) single bus interleaves; out clock 40/80
// (RULE4) per-channel 40 MHz sample clock derived internally
// (RULE5) configuration register resets to all zeros
// (RULE6) commit at rise after 16th fall or deselect
// (RULE7) short frame aborted, register left unchanged
// (RULE8) gains applied on second sample-clock fall
// (RULE9) gain transfer crosses domains glitch free
// (RULE10) format, mode, bus select apply immediately
// (RULE11) format bit: 0 unsigned, 1 output_format_select complement
// (RULE12) independent 5-bit gain code per channel
// (RULE13) gain rises monotonically with code value
// (RULE14) both channels sampled at same instant
// (RULE15) five stages of two bits combined
// (RULE16) acquire while sample clock low, hold high
// (RULE17) dual bus latency 8 or 4 cycles
// (RULE18) single bus latency 8 and 9 cycles
// (RULE19) master selects early, data valid at falls
// (RULE20) frame field positions kept as named constants
// (RULE21) output_format_select complement by inverting msb
module dadc_ctrl (
  input wire logic i_clk,
  input wire logic i_rstn,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [11:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  output logic [31:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr,
  input wire logic i_sclk,
  input wire logic i_cs_n,
  input wire logic i_sdi,
  input wire logic i_cnv_clk_en,
  input wire logic [`DADC_WORD_W-1:0] i_raw_a,
  input wire logic [`DADC_WORD_W-1:0] i_raw_b,
  output logic [`DADC_WORD_W-1:0] o_bus_a,
  output logic [`DADC_WORD_W-1:0] o_bus_b,
  output logic o_output_data_clock,
  output logic o_bus_is_b,
  output logic o_sample_hold,
  output logic [`DADC_GAIN_W-1:0] o_gain_a,
  output logic [`DADC_GAIN_W-1:0] o_gain_b,
  output logic o_output_format_select,
  output logic o_mode,
  output logic o_single_bus_select
);

  dadc_pkg::dadc_state_t st_r;
  dadc_pkg::dadc_state_t st_nxt;
  logic [`DADC_CHANS-1:0][`DADC_WORD_W-1:0] raw_w;
  logic [`DADC_CHANS-1:0][`DADC_WORD_W-1:0] word_w;
  logic sclk_fall;
  logic sclk_rise;
  logic fast_w;
  logic samp_w;
  logic fall_w;
  logic apb_setup;
  logic apb_wr;
  logic [31:0] rd_w;
  logic rd_err_w;

  function automatic logic [`DADC_WORD_W-1:0] dadc_fmt(
    input logic [`DADC_WORD_W-1:0] w,
    input logic output_format_select
  );
    dadc_fmt = output_format_select ? {~w[`DADC_WORD_W-1], w[`DADC_WORD_W-2:0]} : w; // RULE11 RULE21
  endfunction : dadc_fmt

  // ------------------------------------------------------------
  // channel pipelines
  // ------------------------------------------------------------
  assign raw_w = {i_raw_b, i_raw_a};

  genvar ch;
  generate
    for (ch = 0; ch < `DADC_CHANS; ch++)
    begin : g_chan
      // one shared sample enable for both channels
      dadc_pipe u_pipe ( // RULE14
        .i_clk(i_clk),
        .i_rstn(i_rstn),
        .i_sample(samp_w),
        .i_raw(raw_w[ch]),
        .o_word(word_w[ch])
      );
    end
  endgenerate

  // ------------------------------------------------------------
  // event decode
  // ------------------------------------------------------------
  assign sclk_fall = st_r.sclk_p & ~st_r.sclk_q;
  assign sclk_rise = ~st_r.sclk_p & st_r.sclk_q;
  // only mode1 with dual bus runs from a 40 MHz input clock
  assign fast_w = ~(st_r.cfg.mode & ~st_r.cfg.single_bus_select); // RULE1 RULE2 RULE3
  // fast input clock is halved into the sample clock
  assign samp_w = i_cnv_clk_en & (~fast_w | ~st_r.ph); // RULE4
  assign fall_w = i_cnv_clk_en & (~fast_w | st_r.ph); // RULE4

  // ------------------------------------------------------------
  // apb read decode
  // ------------------------------------------------------------
  always_comb
  begin
    rd_w = '0;
    rd_err_w = 1'b0;
    if (i_paddr == `DADC_OFF_CTRL)
    begin
      rd_w[`DADC_CTRL_SER_OFF] = st_r.ctrl_ser_off;
      rd_w[`DADC_CTRL_LSB_FIRST] = st_r.ctrl_lsb_first;
    end
    else if (i_paddr == `DADC_OFF_CFG)
    begin
      rd_w[`DADC_FRM_GAIN_A_LSB +: `DADC_GAIN_W] = st_r.cfg.gain_a;
      rd_w[`DADC_FRM_GAIN_B_LSB +: `DADC_GAIN_W] = st_r.cfg.gain_b;
      rd_w[`DADC_FRM_OUTPUT_FORMAT_SELECT] = st_r.cfg.output_format_select;
      rd_w[`DADC_FRM_MODE] = st_r.cfg.mode;
      rd_w[`DADC_FRM_SINGLE_BUS_SELECT] = st_r.cfg.single_bus_select;
    end
    else if (i_paddr == `DADC_OFF_STAT)
    begin
      rd_w[`DADC_STAT_INCOMPLETE] = st_r.stat_incomplete;
      rd_w[`DADC_STAT_BUSY] = (st_r.ser_state != dadc_pkg::DADC_SER_IDLE);
      rd_w[`DADC_STAT_CNT_LSB +: `DADC_CNT_W] = st_r.commit_cnt;
    end
    else if (i_paddr == `DADC_OFF_GAIN)
    begin
      rd_w[0 +: `DADC_GAIN_W] = st_r.app_a;
      rd_w[`DADC_GAIN_B_LSB +: `DADC_GAIN_W] = st_r.app_b;
    end
    else
    begin
      rd_err_w = 1'b1;
    end
  end

  assign apb_setup = i_psel & ~i_penable;
  assign apb_wr = i_psel & i_penable & i_pwrite & st_r.pready & ~st_r.pslverr;

  // ------------------------------------------------------------
  // next state
  // ------------------------------------------------------------
  always_comb
  begin
    logic full;
    logic commit;
    logic [`DADC_FRM_W-1:0] sh_in;
    logic [`DADC_FRM_W-1:0] sh_v;
    logic [`DADC_WORD_W-1:0] fa;
    logic [`DADC_WORD_W-1:0] fb;
    full = 1'b0;
    commit = 1'b0;
    sh_in = '0;
    sh_v = '0;
    fa = '0;
    fb = '0;
    st_nxt = st_r;

    // bus slave: answer prepared during setup, ready in access
    st_nxt.pready = apb_setup;
    if (apb_setup)
    begin
      st_nxt.prdata = rd_w;
      st_nxt.pslverr = rd_err_w;
    end
    if (apb_wr && i_paddr == `DADC_OFF_CTRL)
    begin
      st_nxt.ctrl_ser_off = i_pwdata[`DADC_CTRL_SER_OFF];
      st_nxt.ctrl_lsb_first = i_pwdata[`DADC_CTRL_LSB_FIRST];
    end
    if (apb_wr && i_paddr == `DADC_OFF_STAT && i_pwdata[`DADC_STAT_INCOMPLETE])
    begin
      st_nxt.stat_incomplete = 1'b0;
    end

    // serial pin sampling
    st_nxt.sclk_q = i_sclk;
    st_nxt.sclk_p = st_r.sclk_q;
    st_nxt.cs_act_q = ~i_cs_n;
    st_nxt.sdi_q = i_sdi;
    // data bit taken at each falling serial clock edge of a frame, up to the 16th; later falls are ignored
    if (st_r.ctrl_lsb_first) // RULE19
      sh_in = {st_r.sdi_q, st_r.shift[`DADC_FRM_W-1:1]};
    else
      sh_in = {st_r.shift[`DADC_FRM_W-2:0], st_r.sdi_q};

    case (st_r.ser_state)
      dadc_pkg::DADC_SER_IDLE:
      begin
        if (st_r.cs_act_q && !st_r.ctrl_ser_off)
        begin
          st_nxt.ser_state = dadc_pkg::DADC_SER_SHIFT;
          st_nxt.bit_cnt = '0;
          if (sclk_fall)
          begin
            st_nxt.shift = sh_in;
            st_nxt.bit_cnt = 5'h01;
          end
        end
      end
      dadc_pkg::DADC_SER_SHIFT:
      begin
        if (sclk_fall)
        begin
          st_nxt.shift = sh_in;
          st_nxt.bit_cnt = st_r.bit_cnt + 5'h01;
          full = (st_r.bit_cnt == `DADC_FRM_LAST);
        end
        sh_v = st_nxt.shift;
        if (!st_r.cs_act_q)
        begin
          st_nxt.ser_state = dadc_pkg::DADC_SER_IDLE;
          if (full)
            commit = 1'b1; // RULE6
          else
            st_nxt.stat_incomplete = 1'b1; // RULE7
        end
        else if (full)
        begin
          st_nxt.ser_state = dadc_pkg::DADC_SER_WAIT;
        end
      end
      dadc_pkg::DADC_SER_WAIT:
      begin
        sh_v = st_r.shift;
        if (sclk_rise || !st_r.cs_act_q)
        begin
          commit = 1'b1; // RULE6
          if (st_r.cs_act_q)
            st_nxt.ser_state = dadc_pkg::DADC_SER_DONE;
          else
            st_nxt.ser_state = dadc_pkg::DADC_SER_IDLE;
        end
      end
      dadc_pkg::DADC_SER_DONE:
      begin
        // extra clocks after a committed frame are ignored
        if (!st_r.cs_act_q)
          st_nxt.ser_state = dadc_pkg::DADC_SER_IDLE;
      end
      default:
      begin
        st_nxt.ser_state = dadc_pkg::DADC_SER_IDLE;
      end
    endcase

    // gain resync: stage on first sample fall, apply on second
    if (fall_w && st_r.pend)
    begin
      st_nxt.stage_a = st_r.cfg.gain_a; // RULE9
      st_nxt.stage_b = st_r.cfg.gain_b; // RULE9
      st_nxt.pend = 1'b0;
      st_nxt.arm = 1'b1;
    end
    else if (fall_w && st_r.arm)
    begin
      st_nxt.app_a = st_r.stage_a; // RULE8
      st_nxt.app_b = st_r.stage_b; // RULE8
      st_nxt.arm = 1'b0;
    end

    if (commit)
    begin
      st_nxt.cfg.gain_a = sh_v[`DADC_FRM_GAIN_A_LSB +: `DADC_GAIN_W]; // RULE12 RULE20
      st_nxt.cfg.gain_b = sh_v[`DADC_FRM_GAIN_B_LSB +: `DADC_GAIN_W]; // RULE12 RULE20
      st_nxt.cfg.output_format_select = sh_v[`DADC_FRM_OUTPUT_FORMAT_SELECT]; // RULE10 RULE20
      st_nxt.cfg.mode = sh_v[`DADC_FRM_MODE]; // RULE10 RULE20
      st_nxt.cfg.single_bus_select = sh_v[`DADC_FRM_SINGLE_BUS_SELECT]; // RULE10 RULE20
      st_nxt.commit_cnt = st_r.commit_cnt + `DADC_CNT_W'(1);
      st_nxt.pend = 1'b1;
    end

    // sample clock phase: high holds, low acquires
    if (i_cnv_clk_en)
      st_nxt.ph = fast_w ? ~st_r.ph : 1'b0;
    st_nxt.hold = fast_w ? st_nxt.ph : i_cnv_clk_en; // RULE16

    // output buses
    fa = dadc_fmt(word_w[0], st_r.cfg.output_format_select);
    fb = dadc_fmt(word_w[1], st_r.cfg.output_format_select);
    if (samp_w)
    begin
      st_nxt.bus_a = fa; // RULE17 RULE18
      st_nxt.bus_is_b = 1'b0;
      if (st_r.cfg.single_bus_select)
      begin
        st_nxt.held_b = fb;
        st_nxt.bus_b = '0;
      end
      else
      begin
        st_nxt.bus_b = fb; // RULE17
      end
    end
    else if (fall_w && st_r.cfg.single_bus_select)
    begin
      // second channel one input clock after the first
      st_nxt.bus_a = st_r.held_b; // RULE3 RULE18
      st_nxt.bus_is_b = 1'b1;
    end

    // output clock: one pulse per input edge in mode1, else half rate
    if (st_r.cfg.mode)
      st_nxt.out_clk = i_cnv_clk_en; // RULE2 RULE3
    else if (samp_w)
      st_nxt.out_clk = 1'b1; // RULE1 RULE3
    else if (fall_w)
      st_nxt.out_clk = 1'b0;
  end

  // ------------------------------------------------------------
  // state register
  // ------------------------------------------------------------
  always_ff @(posedge i_clk or negedge i_rstn)
  begin
    if (!i_rstn)
      st_r <= '0; // RULE5
    else
      st_r <= st_nxt;
  end

  // ------------------------------------------------------------
  // outputs
  // ------------------------------------------------------------
  assign o_prdata = st_r.prdata;
  assign o_pready = st_r.pready;
  assign o_pslverr = st_r.pslverr;
  assign o_bus_a = st_r.bus_a;
  assign o_bus_b = st_r.bus_b;
  assign o_output_data_clock = st_r.out_clk;
  assign o_bus_is_b = st_r.bus_is_b;
  assign o_sample_hold = st_r.hold;
  // code passed unchanged; amplifier gain is monotonic in it
  assign o_gain_a = st_r.app_a; // RULE13
  assign o_gain_b = st_r.app_b; // RULE13
  assign o_output_format_select = st_r.cfg.output_format_select;
  assign o_mode = st_r.cfg.mode;
  assign o_single_bus_select = st_r.cfg.single_bus_select;

endmodule : dadc_ctrl

// ===== tb/dadc_ctrl_asserts.sv
// pin-level assertions of the converter control block
// assumes a bind into dadc_ctrl and one clock domain
`include "dadc_regs.svh"

module dadc_ctrl_asserts (
  input wire logic i_clk,
  input wire logic i_rstn,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic [11:0] i_paddr,
  input wire logic o_pready,
  input wire logic o_pslverr,
  input wire logic i_sclk,
  input wire logic i_cs_n,
  input wire logic i_cnv_clk_en,
  input wire logic [`DADC_GAIN_W-1:0] o_gain_a,
  input wire logic [`DADC_GAIN_W-1:0] o_gain_b,
  input wire logic o_output_data_clock,
  input wire logic o_bus_is_b,
  input wire logic o_output_format_select,
  input wire logic o_mode,
  input wire logic o_single_bus_select
);
  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (!i_rstn);
  sequence setup_s;
    i_psel && !i_penable;
  endsequence
  sequence cfg_move_s;
    $changed({o_mode, o_single_bus_select, o_output_format_select});
  endsequence
  apb_answer_a: assert property (setup_s |=> o_pready)
    else $error("no answer after setup");
  pready_pulse_a: assert property (o_pready |=> !o_pready)
    else $error("pready longer than one cycle");
  unmapped_err_a: assert property (setup_s and i_paddr > 12'h00c |=> o_pslverr)
    else $error("no error on unmapped address");
  cfg_reset_a: assert property ($rose(i_rstn) |-> {o_gain_a, o_gain_b, o_mode} == '0)
    else $error("config not zero after reset");
  cfg_commit_a: assert property (cfg_move_s |->
    ($past(i_sclk, 2) && !$past(i_sclk, 3)) || ($past(i_cs_n, 2) && !$past(i_cs_n, 3)))
    else $error("config moved without a commit");
  gain_tick_a: assert property ($changed({o_gain_a, o_gain_b}) |->
    $past(i_cnv_clk_en) || $past(i_cnv_clk_en, 2))
    else $error("gain moved off a sample clock fall");
  oclk_pulse_a: assert property (o_mode && $past(o_mode) |->
    o_output_data_clock == $past(i_cnv_clk_en))
    else $error("output clock not one pulse per tick");
  oclk_slow_a: assert property (!o_mode && !$past(o_mode) &&
    $changed(o_output_data_clock) |-> $past(i_cnv_clk_en))
    else $error("output clock moved without a tick");
  bus_b_tick_a: assert property ($rose(o_bus_is_b) |-> $past(i_cnv_clk_en))
    else $error("channel b shown off a tick");
endmodule : dadc_ctrl_asserts

bind dadc_ctrl dadc_ctrl_asserts u_chk (.i_clk, .i_rstn, .i_psel, .i_penable, .i_paddr,
  .o_pready, .o_pslverr, .i_sclk, .i_cs_n, .i_cnv_clk_en, .o_gain_a, .o_gain_b,
  .o_output_data_clock, .o_bus_is_b, .o_output_format_select, .o_mode,
  .o_single_bus_select);

// ===== tb/dadc_ser_master.sv
// serial configuration master driving the frame pins
// assumes each serial level is held two system clocks
module dadc_ser_master (
  input wire logic i_clk,
  output logic o_sclk,
  output logic o_cs_n,
  output logic o_sdi
);
  timeunit 1ns;
  timeprecision 1ps;
  initial
  begin
    o_sclk = 1'b1;
    o_cs_n = 1'b1;
    o_sdi = 1'b0;
  end
  // ------------------------------------------------------------
  // frame: first n bits of w, msb first
  // ------------------------------------------------------------
  task automatic send(input logic [15:0] w, input int n);
    @(posedge i_clk);
    o_cs_n <= 1'b0;
    repeat (2) @(posedge i_clk);
    for (int i = 15; i > 15 - n; i--)
    begin
      o_sclk <= 1'b0;
      o_sdi <= w[i];
      repeat (2) @(posedge i_clk);
      o_sclk <= 1'b1;
      repeat (2) @(posedge i_clk);
    end
    o_cs_n <= 1'b1;
    o_sdi <= ~o_sdi;
    repeat (2) @(posedge i_clk);
  endtask : send
endmodule : dadc_ser_master

// ===== tb/dual_adc_config_output_ctrl_tb_top.sv
// self-checking bench of the converter control block
// assumes the serial master model and the bound checker
`include "dadc_regs.svh"

module dual_adc_config_output_ctrl_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic i_clk = 1'b0;
  logic i_rstn = 1'b0;
  logic psel = 1'b0;
  logic pen = 1'b0;
  logic pwr = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic tick_en = 1'b0;
  logic [`DADC_WORD_W-1:0] raw_a = 10'h000;
  logic [`DADC_WORD_W-1:0] raw_b = 10'h000;
  logic [`DADC_WORD_W-1:0] bus_a, bus_b;
  logic [`DADC_GAIN_W-1:0] gain_a, gain_b;
  logic [31:0] prdata;
  logic sclk, cs_n, sdi, pready, pslverr, oclk, is_b, sh, fmt, mode, single_bus_select;
  int n_mismatch = 0;
  int samples_checked = 0;

  dadc_ctrl u_dut (.i_clk(i_clk), .i_rstn(i_rstn), .i_psel(psel), .i_penable(pen),
    .i_pwrite(pwr), .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata),
    .o_pready(pready), .o_pslverr(pslverr), .i_sclk(sclk), .i_cs_n(cs_n), .i_sdi(sdi),
    .i_cnv_clk_en(tick_en), .i_raw_a(raw_a), .i_raw_b(raw_b), .o_bus_a(bus_a),
    .o_bus_b(bus_b), .o_output_data_clock(oclk), .o_bus_is_b(is_b), .o_sample_hold(sh),
    .o_gain_a(gain_a), .o_gain_b(gain_b), .o_output_format_select(fmt), .o_mode(mode),
    .o_single_bus_select(single_bus_select));
  dadc_ser_master u_mst (.i_clk(i_clk), .o_sclk(sclk), .o_cs_n(cs_n), .o_sdi(sdi));

  initial
  begin
    forever #25 i_clk = ~i_clk;
  end

  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  task automatic test_done();
    $display("mismatches %0d checks %0d", n_mismatch, samples_checked);
    if (n_mismatch == 0 && samples_checked > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : test_done

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] wd,
    output logic [31:0] rd);
    int n;
    @(posedge i_clk);
    psel <= 1'b1;
    pwr <= w;
    paddr <= a;
    pwdata <= wd;
    @(posedge i_clk);
    pen <= 1'b1;
    n = 0;
    @(posedge i_clk);
    while (pready !== 1'b1 && n < 20)
    begin
      @(posedge i_clk);
      n++;
    end
    rd = prdata;
    chk(32'(pslverr), 32'(a > 12'h00c));
    psel <= 1'b0;
    pen <= 1'b0;
    if (n >= 20)
    begin
      n_mismatch++;
      $display("[ERR] %0t no bus answer", $time);
      test_done();
    end
  endtask : apb

  task automatic tick();
    @(posedge i_clk);
    tick_en <= 1'b1;
    @(posedge i_clk);
    tick_en <= 1'b0;
    @(posedge i_clk);
    @(negedge i_clk);
  endtask : tick

  task automatic frame(input logic [15:0] w, input int n);
    u_mst.send(w, n);
    repeat (4) @(posedge i_clk);
    @(negedge i_clk);
  endtask : frame

  function automatic logic [15:0] cw(input logic s, input logic m, input logic t,
    input logic [4:0] b, input logic [4:0] a);
    return {3'b000, s, m, t, b, a};
  endfunction : cw

  // ------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------
  task automatic s_reset();
    logic [31:0] d;
    chk(32'({gain_a, gain_b, fmt, mode, single_bus_select}), 32'h0);
    chk(32'({bus_a, bus_b, oclk, is_b, sh, pready}), 32'h0);
    apb(1'b0, 12'h004, 32'h0, d);
    chk(d, 32'h0);
    apb(1'b0, 12'h010, 32'h0, d);
  endtask : s_reset

  task automatic s_modes();
    logic [31:0] d;
    logic [15:0] w;
    for (int i = 0; i < 4; i++)
    begin
      w = cw(i[1], i[0], i[0] ^ i[1], 5'(31 - i), 5'(i * 9 + 1));
      frame(w, 16);
      chk(32'({single_bus_select, mode, fmt}), 32'(w[12:10]));
      apb(1'b0, 12'h004, 32'h0, d);
      chk(d, 32'(w[12:0]));
      apb(1'b0, 12'h008, 32'h0, d);
      chk(32'(d[15:8]), 32'(i + 1));
    end
  endtask : s_modes

  task automatic s_abort();
    logic [31:0] c, d;
    apb(1'b0, 12'h004, 32'h0, c);
    apb(1'b1, 12'h000, 32'h1, d);
    frame(16'h1fff, 16);
    apb(1'b0, 12'h004, 32'h0, d);
    chk(d, c);
    apb(1'b1, 12'h000, 32'h0, d);
    frame(16'h1fff, 10);
    apb(1'b0, 12'h004, 32'h0, d);
    chk(d, c);
    apb(1'b0, 12'h008, 32'h0, d);
    chk(32'(d[0]), 32'h1);
    apb(1'b1, 12'h008, 32'h1, d);
    apb(1'b0, 12'h008, 32'h0, d);
    chk(32'(d[0]), 32'h0);
  endtask : s_abort

  task automatic s_gain();
    frame(cw(1'b0, 1'b1, 1'b0, 5'h0a, 5'h15), 16);
    tick();
    // one sample-clock fall since the commit only stages the gain: applied gain still zero
    chk(32'(gain_a), 32'h0);
    tick();
    chk(32'({gain_b, gain_a}), 32'h155);
  endtask : s_gain

  task automatic s_data();
    int nb;
    repeat (6) tick();
    @(posedge i_clk);
    raw_a <= 10'h3ff;
    raw_b <= 10'h155;
    for (int k = 0; k < 5; k++)
    begin
      tick();
      chk(32'(bus_a === 10'h3ff), 32'(k == 4));
    end
    chk(32'(bus_b), 32'h155);
    frame(cw(1'b0, 1'b1, 1'b1, 5'h0a, 5'h15), 16);
    tick();
    chk(32'(bus_a), 32'h1ff);
    chk(32'(bus_b), 32'h355);
    frame(cw(1'b1, 1'b0, 1'b0, 5'h0a, 5'h15), 16);
    repeat (12) tick();
    nb = 0;
    for (int k = 0; k < 4; k++)
    begin
      tick();
      nb += int'(is_b === 1'b1);
      chk(32'(bus_a), (is_b === 1'b1) ? 32'h155 : 32'h3ff);
      chk(32'(bus_b), 32'h0);
      chk(32'({sh, oclk}), (is_b === 1'b1) ? 32'h0 : 32'h3);
    end
    chk(32'(nb), 32'h2);
  endtask : s_data

  initial
  begin
    repeat (5) @(posedge i_clk);
    i_rstn <= 1'b1;
    repeat (2) @(posedge i_clk);
    @(negedge i_clk);
    s_reset();
    s_modes();
    s_abort();
    s_gain();
    s_data();
    test_done();
  end
endmodule : dual_adc_config_output_ctrl_tb_top
